// *** rtl/cmm_pkg.sv ***
package cmm_pkg;

  // Register offsets on the serial management port.
  localparam logic [7:0] CMM_ADDR_CAL_CTRL = 8'h88;
  localparam logic [7:0] CMM_ADDR_FAST_LOCK = 8'h89;
  localparam logic [7:0] CMM_ADDR_SEL_HIGH = 8'h8a;
  localparam logic [7:0] CMM_ADDR_MON_EN = 8'h8b;
  localparam logic [7:0] CMM_ADDR_SKEW1 = 8'h8e;
  localparam logic [7:0] CMM_ADDR_SKEW2 = 8'h8f;

  // Highest offset that holds calibration-sensitive settings.
  localparam logic [7:0] CMM_ADDR_SENS_LAST = 8'h37;

  // Values after reset.
  localparam logic [7:0] CMM_RST_FAST_LOCK = 8'h00;
  localparam logic [7:0] CMM_RST_SEL_HIGH = 8'h03;
  localparam logic [7:0] CMM_RST_MON_EN = 8'hff;
  localparam logic [7:0] CMM_RST_SKEW = 8'h00;
  localparam logic [7:0] CMM_RST_CAL_CTRL = 8'h00;

  // Field positions.
  localparam int CMM_BIT_QUICK = 0;
  localparam int CMM_BIT_CAL_START = 6;
  localparam int CMM_BIT_SEL_HIGH_IN1 = 0;
  localparam int CMM_BIT_LOS_LOW_IN1 = 4;
  localparam int CMM_BIT_FOS_IN1 = 0;

  // Cycles the sequencer waits before it trusts the lock-loss alarm.
  localparam logic [3:0] CMM_CAL_SETTLE_CYC = 4'h4;

  // Loss monitor select codes.
  typedef enum logic [1:0] {
    CMM_LOSS_OFF = 2'b00,
    CMM_LOSS_RSVD = 2'b01,
    CMM_LOSS_SLOW = 2'b10,
    CMM_LOSS_NORMAL = 2'b11
  } cmm_loss_sel_t;

  // One register access from the serial port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmm_reg_req_t;

  // Monitor settings for one input clock.
  typedef struct packed {
    cmm_loss_sel_t loss_sel;
    logic normal_en;
    logic slow_en;
    logic freq_en;
  } cmm_mon_t;

endpackage : cmm_pkg

// *** rtl/cmm_cal_seq.sv ***
`timescale 1ns/100ps
module cmm_cal_seq import cmm_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Requests from the register bank.
  input wire logic start_i,
  input wire logic sens_wr_i,
  // Alarm from the PLL.
  input wire logic lock_loss_alarm_i,
  // Status.
  output logic cal_busy_o,
  output logic calibrated_o,
  output logic recal_needed_o
);

  typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_WAIT} cmm_cal_state_t;

  cmm_cal_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic calibrated_q, calibrated_d;
  logic recal_q, recal_d;

  // Next state: a start always restarts the sequence, even mid-run.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    calibrated_d = calibrated_q;
    case (state_q)
      CAL_SETTLE: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == CMM_CAL_SETTLE_CYC - 4'h1) begin
          state_d = CAL_WAIT;
        end
      end
      CAL_WAIT: begin
        if (!lock_loss_alarm_i) begin
          state_d = CAL_IDLE;
          calibrated_d = 1'b1;
        end
      end
      default: begin
        state_d = CAL_IDLE;
      end
    endcase
    if (start_i) begin
      state_d = CAL_SETTLE;
      cnt_d = 4'h0;
      calibrated_d = 1'b0;
    end
  end

  // A sensitive write after a good calibration asks for a new one; set wins over clear.
  assign recal_d = (sens_wr_i && calibrated_q) ? 1'b1 : (start_i ? 1'b0 : recal_q);

  // State registers.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= CAL_IDLE;
      cnt_q <= 4'h0;
      calibrated_q <= 1'b0;
      recal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      calibrated_q <= calibrated_d;
      recal_q <= recal_d;
    end
  end

  assign cal_busy_o = (state_q != CAL_IDLE);
  assign calibrated_o = calibrated_q;
  assign recal_needed_o = recal_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_settle;
    cal_busy_o [*4];
  endsequence

  // A start keeps the sequencer busy for the settle time.
  property p_cal_settle;
    start_i |=> s_settle;
  endproperty
  a_cal_settle: assert property (p_cal_settle) else $error("calibration ended before settle time");

  // Alarm low while waiting ends calibration next cycle.
  property p_cal_done;
    (state_q == CAL_WAIT) && !lock_loss_alarm_i && !start_i |=> calibrated_o && !cal_busy_o;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("calibration did not complete on alarm low");

  // Sensitive write after calibration flags a new calibration.
  property p_recal;
    sens_wr_i && calibrated_o |=> recal_needed_o;
  endproperty
  a_recal: assert property (p_recal) else $error("sensitive change not flagged");

endmodule : cmm_cal_seq

// *** rtl/cmm_config_regs.sv ***
`timescale 1ns/100ps
module cmm_config_regs import cmm_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register access from the serial management port.
  input wire cmm_reg_req_t req_i,
  output logic [7:0] rdata_o,
  // Settings to the PLL, monitors and output dividers.
  output logic quick_acquire_enable_o,
  output cmm_mon_t [1:0] mon_o,
  output logic signed [7:0] out1_phase_skew_o,
  output logic signed [7:0] out2_phase_skew_o,
  // Calibration.
  input wire logic lock_loss_alarm_i,
  output logic self_calibration_start_o,
  output logic cal_busy_o,
  output logic calibrated_o,
  output logic recal_needed_o
);

  // Offsets 0 to 55 hold settings the PLL only picks up on calibration.
  function automatic logic is_cal_sensitive(input logic [7:0] addr);
    is_cal_sensitive = (addr <= CMM_ADDR_SENS_LAST);
  endfunction : is_cal_sensitive

  logic quick_q;
  logic [1:0] sel_high_q;
  logic [1:0] los_low_q;
  logic [1:0] fos_q;
  logic [1:0][7:0] skew_q;
  logic cal_start_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Write strobes per register.
  logic wr_cal;
  logic wr_fast;
  logic wr_sel_high;
  logic wr_mon_en;
  logic wr_skew1;
  logic wr_skew2;
  logic sens_wr;
  logic cal_req;

  assign wr_cal = req_i.wr && (req_i.addr == CMM_ADDR_CAL_CTRL);
  assign wr_fast = req_i.wr && (req_i.addr == CMM_ADDR_FAST_LOCK);
  assign wr_sel_high = req_i.wr && (req_i.addr == CMM_ADDR_SEL_HIGH);
  assign wr_mon_en = req_i.wr && (req_i.addr == CMM_ADDR_MON_EN);
  assign wr_skew1 = req_i.wr && (req_i.addr == CMM_ADDR_SKEW1);
  assign wr_skew2 = req_i.wr && (req_i.addr == CMM_ADDR_SKEW2);
  assign sens_wr = req_i.wr && is_cal_sensitive(req_i.addr);
  assign cal_req = wr_cal && req_i.wdata[CMM_BIT_CAL_START];

  // Fast-lock enable; only bit 0 is stored.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      quick_q <= CMM_RST_FAST_LOCK[CMM_BIT_QUICK];
    end else if (wr_fast) begin
      quick_q <= req_i.wdata[CMM_BIT_QUICK];
    end
  end

  // Upper halves of the loss monitor selects.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sel_high_q <= CMM_RST_SEL_HIGH[CMM_BIT_SEL_HIGH_IN1 +: 2];
    end else if (wr_sel_high) begin
      sel_high_q <= req_i.wdata[CMM_BIT_SEL_HIGH_IN1 +: 2];
    end
  end

  // Lower halves of the loss selects and the frequency-offset enables.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      los_low_q <= CMM_RST_MON_EN[CMM_BIT_LOS_LOW_IN1 +: 2];
      fos_q <= CMM_RST_MON_EN[CMM_BIT_FOS_IN1 +: 2];
    end else if (wr_mon_en) begin
      los_low_q <= req_i.wdata[CMM_BIT_LOS_LOW_IN1 +: 2];
      fos_q <= req_i.wdata[CMM_BIT_FOS_IN1 +: 2];
    end
  end

  // Output phase skews, held as two's complement.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      skew_q <= {CMM_RST_SKEW, CMM_RST_SKEW};
    end else begin
      if (wr_skew1) begin
        skew_q[0] <= req_i.wdata;
      end
      if (wr_skew2) begin
        skew_q[1] <= req_i.wdata;
      end
    end
  end

  // The start bit lives one cycle and then clears itself.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cal_start_q <= CMM_RST_CAL_CTRL[CMM_BIT_CAL_START];
    end else begin
      cal_start_q <= cal_req;
    end
  end

  // Read multiplexer; reserved bits return their reset values, unmapped offsets zero.
  always_comb begin
    rdata_d = 8'h00;
    if (req_i.addr == CMM_ADDR_CAL_CTRL) begin
      rdata_d = CMM_RST_CAL_CTRL;
      rdata_d[CMM_BIT_CAL_START] = cal_start_q;
    end else if (req_i.addr == CMM_ADDR_FAST_LOCK) begin
      rdata_d = CMM_RST_FAST_LOCK;
      rdata_d[CMM_BIT_QUICK] = quick_q;
    end else if (req_i.addr == CMM_ADDR_SEL_HIGH) begin
      rdata_d = CMM_RST_SEL_HIGH & 8'h03;
      rdata_d[CMM_BIT_SEL_HIGH_IN1 +: 2] = sel_high_q;
    end else if (req_i.addr == CMM_ADDR_MON_EN) begin
      rdata_d = CMM_RST_MON_EN;
      rdata_d[CMM_BIT_LOS_LOW_IN1 +: 2] = los_low_q;
      rdata_d[CMM_BIT_FOS_IN1 +: 2] = fos_q;
    end else if (req_i.addr == CMM_ADDR_SKEW1) begin
      rdata_d = skew_q[0];
    end else if (req_i.addr == CMM_ADDR_SKEW2) begin
      rdata_d = skew_q[1];
    end
  end

  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (req_i.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Monitor settings per input clock, joined from the two split halves.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mon
      assign mon_o[gi].loss_sel = cmm_loss_sel_t'({sel_high_q[gi], los_low_q[gi]});
      assign mon_o[gi].normal_en = (mon_o[gi].loss_sel == CMM_LOSS_NORMAL);
      assign mon_o[gi].slow_en = (mon_o[gi].loss_sel == CMM_LOSS_SLOW);
      assign mon_o[gi].freq_en = fos_q[gi];
    end
  endgenerate

  // Calibration sequencer tracks the run and pending recalibration.
  cmm_cal_seq i_cmm_cal_seq (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_i(cal_start_q),
    .sens_wr_i(sens_wr),
    .lock_loss_alarm_i(lock_loss_alarm_i),
    .cal_busy_o(cal_busy_o),
    .calibrated_o(calibrated_o),
    .recal_needed_o(recal_needed_o)
  );

  // Outputs straight from the registers.
  assign rdata_o = rdata_q;
  assign quick_acquire_enable_o = quick_q;
  assign out1_phase_skew_o = skew_q[0];
  assign out2_phase_skew_o = skew_q[1];
  assign self_calibration_start_o = cal_start_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_start_pulse;
    self_calibration_start_o ##1 !self_calibration_start_o;
  endsequence

  // Fast-lock write lands on the next edge.
  property p_quick_write;
    wr_fast |=> quick_acquire_enable_o == $past(req_i.wdata[0]);
  endproperty
  a_quick_write: assert property (p_quick_write) else $error("fast-lock enable not written");

  // The upper select bit of input two comes from bit 1 of register 0x8a.
  property p_sel_split;
    wr_sel_high && !wr_mon_en |=> mon_o[1].loss_sel[1] == $past(req_i.wdata[1]) && $stable(los_low_q);
  endproperty
  a_sel_split: assert property (p_sel_split) else $error("split loss select wrong");

  // Code 11 selects the normal monitor only.
  property p_dec_normal;
    mon_o[0].loss_sel == CMM_LOSS_NORMAL |-> mon_o[0].normal_en && !mon_o[0].slow_en;
  endproperty
  a_dec_normal: assert property (p_dec_normal) else $error("normal loss monitor decode wrong");

  // Code 10 selects the slow monitor only; other codes keep it off.
  property p_dec_slow;
    mon_o[1].slow_en == (mon_o[1].loss_sel == CMM_LOSS_SLOW) && !(mon_o[1].slow_en && mon_o[1].normal_en);
  endproperty
  a_dec_slow: assert property (p_dec_slow) else $error("slow loss monitor decode wrong");

  // Frequency-offset enables follow bits 1:0 of register 0x8b.
  property p_fos_write;
    wr_mon_en |=> {mon_o[1].freq_en, mon_o[0].freq_en} == $past(req_i.wdata[1:0]);
  endproperty
  a_fos_write: assert property (p_fos_write) else $error("frequency monitor enable wrong");

  // After reset the normal loss and frequency-offset monitors of both inputs are on.
  property p_mon_reset;
    @(posedge clk_sys_i) disable iff (1'b0) reset_i |=> mon_o[0].normal_en && mon_o[1].normal_en && (fos_q == 2'b11);
  endproperty
  a_mon_reset: assert property (p_mon_reset) else $error("monitors not enabled after reset");

  // A skew holds unless its own register is written.
  property p_skew_hold;
    !wr_skew1 |=> $stable(out1_phase_skew_o);
  endproperty
  a_skew_hold: assert property (p_skew_hold) else $error("output one skew changed without write");

  // A start write gives a one-cycle start pulse.
  property p_start_pulse;
    cal_req |=> s_start_pulse;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start bit did not self-clear");

  // Reserved fast-lock bits read zero.
  property p_reserved_read;
    req_i.rd && req_i.addr == CMM_ADDR_FAST_LOCK |=> rdata_o[7:1] == 7'h00;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read nonzero");

  // Input one's upper select bit comes from bit 0 of register 0x8a.
  property p_sel_split_in1;
    wr_sel_high |=> mon_o[0].loss_sel[1] == $past(req_i.wdata[0]);
  endproperty
  a_sel_split_in1: assert property (p_sel_split_in1) else $error("input one upper loss select wrong");

  // The lower select bits of both inputs come from bits 5:4 of register 0x8b.
  property p_low_split;
    wr_mon_en |=> {mon_o[1].loss_sel[0], mon_o[0].loss_sel[0]} == $past(req_i.wdata[5:4]);
  endproperty
  a_low_split: assert property (p_low_split) else $error("lower loss select bits wrong");

  // Codes 00 and 01 leave both loss monitors of input two off.
  property p_dec_off;
    !mon_o[1].loss_sel[1] |-> !mon_o[1].normal_en && !mon_o[1].slow_en;
  endproperty
  a_dec_off: assert property (p_dec_off) else $error("loss monitor on for a disabled code");

  // The fast-lock enable holds unless its register is written.
  property p_quick_hold;
    !wr_fast |=> $stable(quick_acquire_enable_o);
  endproperty
  a_quick_hold: assert property (p_quick_hold) else $error("fast-lock enable changed without write");

  // A write to register 0x8e lands on output one's skew.
  property p_skew1_write;
    wr_skew1 |=> out1_phase_skew_o == $past(req_i.wdata);
  endproperty
  a_skew1_write: assert property (p_skew1_write) else $error("output one skew not written");

  // A write to register 0x8f lands on output two's skew.
  property p_skew2_write;
    wr_skew2 |=> out2_phase_skew_o == $past(req_i.wdata);
  endproperty
  a_skew2_write: assert property (p_skew2_write) else $error("output two skew not written");

  // Output two's skew holds unless its own register is written.
  property p_skew2_hold;
    !wr_skew2 |=> $stable(out2_phase_skew_o);
  endproperty
  a_skew2_hold: assert property (p_skew2_hold) else $error("output two skew changed without write");

  // A start pulse only ever follows a start write.
  property p_start_cause;
    self_calibration_start_o |-> $past(cal_req);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start pulse without start write");

  // Reserved bits of register 0x8a read zero.
  property p_sel_reserved_read;
    req_i.rd && req_i.addr == CMM_ADDR_SEL_HIGH |=> rdata_o[7:2] == 6'h00;
  endproperty
  a_sel_reserved_read: assert property (p_sel_reserved_read) else $error("select reserved bits wrong");

  // Reserved bits of register 0x8b read back as ones.
  property p_mon_reserved_read;
    req_i.rd && req_i.addr == CMM_ADDR_MON_EN |=> rdata_o[7:6] == 2'b11 && rdata_o[3:2] == 2'b11;
  endproperty
  a_mon_reserved_read: assert property (p_mon_reserved_read) else $error("enable reserved bits wrong");

  // Reserved bits of register 0x88 read zero.
  property p_cal_reserved_read;
    req_i.rd && req_i.addr == CMM_ADDR_CAL_CTRL |=> rdata_o[7] == 1'b0 && rdata_o[5:0] == 6'h00;
  endproperty
  a_cal_reserved_read: assert property (p_cal_reserved_read) else $error("start reserved bits wrong");

endmodule : cmm_config_regs

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb_top import cmm_pkg::*;;
  // Bench clock, reset and design ports.
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  cmm_reg_req_t req = '0;
  logic lock_loss_alarm = 1'b1;
  logic [7:0] rdata;
  logic quick;
  cmm_mon_t [1:0] mon;
  logic signed [7:0] skew1;
  logic signed [7:0] skew2;
  logic cal_start;
  logic cal_busy;
  logic calibrated;
  logic recal_needed;
  int miscompares = 0;
  int checks_done = 0;

  // The clock toggles every half period of 20 ns.
  always #20 clk_sys = ~clk_sys;

  // Register bank under test.
  cmm_config_regs i_cmm_config_regs (
    .clk_sys_i(clk_sys),
    .reset_i(reset),
    .req_i(req),
    .rdata_o(rdata),
    .quick_acquire_enable_o(quick),
    .mon_o(mon),
    .out1_phase_skew_o(skew1),
    .out2_phase_skew_o(skew2),
    .lock_loss_alarm_i(lock_loss_alarm),
    .self_calibration_start_o(cal_start),
    .cal_busy_o(cal_busy),
    .calibrated_o(calibrated),
    .recal_needed_o(recal_needed)
  );

  // One write strobe, held for exactly one taking edge.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clk_sys);
    #1;
    req.wr = 1'b0;
  endtask : reg_write

  // One read strobe; the data is compared 1 ns after the taking edge.
  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk_sys);
    #1;
    req.rd = 1'b0;
    `CHK($sformatf("register %h", a), exp, rdata)
  endtask : check_reg

  // Compares the decoded monitor settings of one input against a select code.
  task automatic check_mon(input int idx, input logic [1:0] code, input logic fos);
    `CHK("loss select", code, mon[idx].loss_sel)
    `CHK("normal loss enable", code == 2'b11, mon[idx].normal_en)
    `CHK("slow loss enable", code == 2'b10, mon[idx].slow_en)
    `CHK("offset enable", fos, mon[idx].freq_en)
  endtask : check_mon

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end

  // Main test sequence.
  initial begin
    logic [1:0] c;
    logic [1:0] d;
    int n;
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    // Values after reset.
    check_reg(CMM_ADDR_FAST_LOCK, 8'h00);
    check_reg(CMM_ADDR_SEL_HIGH, CMM_RST_SEL_HIGH);
    check_reg(CMM_ADDR_MON_EN, 8'hff);
    check_reg(CMM_ADDR_SKEW1, 8'h00);
    check_reg(CMM_ADDR_SKEW2, 8'h00);
    check_reg(CMM_ADDR_CAL_CTRL, 8'h00);
    check_mon(0, 2'b11, 1'b1);
    check_mon(1, 2'b11, 1'b1);
    // Fast-lock bit; the reserved bits are written back as they were read.
    reg_write(CMM_ADDR_FAST_LOCK, 8'h01);
    `CHK("quick acquire", 1'b1, quick)
    check_reg(CMM_ADDR_FAST_LOCK, 8'h01);
    reg_write(CMM_ADDR_FAST_LOCK, 8'h00);
    `CHK("quick acquire", 1'b0, quick)
    // Every loss select code, different on the two inputs.
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      d = 2'(3 - k);
      reg_write(CMM_ADDR_SEL_HIGH, {6'h3f, d[1], c[1]});
      reg_write(CMM_ADDR_MON_EN, {2'b00, d[0], c[0], 2'b00, 2'b11});
      check_mon(0, c, 1'b1);
      check_mon(1, d, 1'b1);
      check_reg(CMM_ADDR_SEL_HIGH, {6'h00, d[1], c[1]});
      check_reg(CMM_ADDR_MON_EN, {2'b11, d[0], c[0], 2'b11, 2'b11});
    end
    // Offset monitor enabled on input two only.
    reg_write(CMM_ADDR_MON_EN, 8'h02);
    `CHK("offset enable one", 1'b0, mon[0].freq_en)
    `CHK("offset enable two", 1'b1, mon[1].freq_en)
    check_reg(CMM_ADDR_MON_EN, 8'hce);
    // Signed skew extremes.
    reg_write(CMM_ADDR_SKEW1, 8'h80);
    reg_write(CMM_ADDR_SKEW2, 8'h7f);
    `CHK("skew one", 8'sh80, skew1)
    `CHK("skew two", 8'sh7f, skew2)
    check_reg(CMM_ADDR_SKEW1, 8'h80);
    check_reg(CMM_ADDR_SKEW2, 8'h7f);
    check_reg(8'h90, 8'h00);
    // Calibration once configuration is done, with the alarm held high past the settle time.
    reg_write(CMM_ADDR_CAL_CTRL, 8'h40);
    `CHK("calibration start", 1'b1, cal_start)
    @(posedge clk_sys);
    #1;
    `CHK("calibration start", 1'b0, cal_start)
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("busy", 1'b1, cal_busy)
    `CHK("calibrated", 1'b0, calibrated)
    lock_loss_alarm = 1'b0;
    n = 0;
    while (cal_busy !== 1'b0 && n < 10) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("busy", 1'b0, cal_busy)
    `CHK("calibrated", 1'b1, calibrated)
    check_reg(CMM_ADDR_CAL_CTRL, 8'h00);
    // Sensitive range boundary, then a new calibration on a settled input clears the flag.
    reg_write(8'h38, 8'h55);
    `CHK("recal needed", 1'b0, recal_needed)
    reg_write(CMM_ADDR_SENS_LAST, 8'h55);
    `CHK("recal needed", 1'b1, recal_needed)
    reg_write(CMM_ADDR_CAL_CTRL, 8'h40);
    @(posedge clk_sys);
    #1;
    `CHK("recal needed", 1'b0, recal_needed)
    `CHK("calibrated", 1'b0, calibrated)
    // A reset in mid-run, during calibration, restores every setting.
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    `CHK("skew one", 8'sh00, skew1)
    `CHK("skew two", 8'sh00, skew2)
    `CHK("busy", 1'b0, cal_busy)
    check_reg(CMM_ADDR_MON_EN, 8'hff);
    check_mon(0, 2'b11, 1'b1);
    check_mon(1, 2'b11, 1'b1);
    summarize();
  end
endmodule : tb_top
